// ===== design/sptx_fifo.sv
// sptx_fifo: small flip-flop FIFO with valid/ready on both sides
// assumes: same clock for both sides, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module sptx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [AW:0]      count;
	logic             do_wr;
	logic             do_rd;

	// honest full and empty from the fill count
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_idx];
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;

	// storage, one entry written per accepted word
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_idx] <= in_data;
		end
	end

	// pointers wrap at depth, which need not be a power of two
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_idx <= '0;
			rd_idx <= '0;
		end else begin
			if (do_wr) begin
				wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
			end
			if (do_rd) begin
				rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
			end
		end
	end

	// occupancy
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= '0;
		end else if (do_wr && !do_rd) begin
			count <= count + 1'b1;
		end else if (do_rd && !do_wr) begin
			count <= count - 1'b1;
		end
	end

endmodule : sptx_fifo

`default_nettype wire

// ===== design/sptx_pkg.sv
// sptx_pkg: shared constants and types for the serial port transmitter
// assumes: a single 40 MHz master clock, no software register bus
package sptx_pkg;

	// ------------------------------------------------------------
	// mode encodings and dividers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SPTX_MODE_UART    = 2'b00,
		SPTX_MODE_MASTER  = 2'b01,
		SPTX_MODE_SLAVE   = 2'b10
	} sptx_mode_t;

	typedef enum logic [2:0] {
		SPTX_ST_IDLE   = 3'b000,
		SPTX_ST_START  = 3'b001,
		SPTX_ST_DATA   = 3'b010,
		SPTX_ST_MPC    = 3'b011,
		SPTX_ST_PARITY = 3'b100,
		SPTX_ST_STOP   = 3'b101,
		SPTX_ST_LEAD   = 3'b110
	} sptx_state_t;

	localparam int         SPTX_DATA_W      = 8;
	localparam int         SPTX_FIFO_DEPTH  = 4;
	localparam logic [3:0] SPTX_UART_DIV_M1 = 4'h0_00F;  // divide by 16, count 0..15
	localparam logic [3:0] SPTX_SYNC_DIV_M1 = 4'h0_003;  // divide by 4, count 0..3
	localparam logic [3:0] SPTX_DIV_ZERO    = 4'h0_000;
	localparam logic [3:0] SPTX_HALF        = 4'h0_002;  // master clock rises half way through a period
	localparam logic [2:0] SPTX_LAST_BIT    = 3'h0_007;
	localparam logic [2:0] SPTX_BIT_ZERO    = 3'h0_000;
	localparam logic [1:0] SPTX_LEAD_TICKS  = 2'h0_002;  // second shift tick starts the master clock
	localparam logic [1:0] SPTX_LEAD_ZERO   = 2'h0_000;
	localparam logic       SPTX_LINE_IDLE   = 1'b1;

endpackage : sptx_pkg

// ===== design/sptx_top.sv
// sptx_top: transmit side of one serial port channel
// assumes: baud tick comes from a baud generator on REF_CLK; the shift
// clock input of slave mode and nothing else arrives from off-chip.
// Notes on behaviour
// - uart shift tick is baud tick over sixteen
// - only a buffer write starts a frame
// - start pulse one clock after the write
// - start pulse fall loads shifter, free low
// - ready irq and flag at instruction begin
// - start bit on next shift tick, pin low
// - data lsb first, optional parity, then stop
// - buffer independent of shifter, back to back
// - pin idles high when serial function selected
// - multiprocessor flag bit after msb, before parity
// - sync master shift tick is baud over four
// - master clock out from second tick, bit0 follows
// - master data changes just before clock falls
// - slave clock edge-detected on master clock
// - slave bit0 at once, later bits after fall
// - sync modes only on the capable channel
`timescale 1ns/100ps
`default_nettype none

module sptx_top #(
	parameter logic SYNC_CAPABLE = 1'b1  // marks the one channel with sync modes
) (
	// clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       RST_N,
	// cpu side
	input  wire logic       TX_BUFFER_WRITE_STROBE,
	input  wire logic [7:0] TX_WRITE_DATA,
	input  wire logic       TX_ADDRESS_MARK,
	output logic            TX_WRITE_READY,
	input  wire logic       INSTRUCTION_BEGIN,
	input  wire logic       SERIAL_IRQ_FLAG_CLEAR,
	// configuration
	input  wire logic [1:0] TX_MODE,
	input  wire logic       TX_PARITY_ENABLE,
	input  wire logic       TX_PARITY_ODD,
	input  wire logic       TX_MULTIPROC_ENABLE,
	input  wire logic       TX_PIN_SERIAL_SELECT,
	// baud generator
	input  wire logic       BAUD_TICK,
	// serial pins
	output logic            TX_DATA_PIN,
	output logic            TX_CLOCK_PIN_OUT,
	output logic            TX_CLOCK_PIN_OE,
	input  wire logic       TX_CLOCK_PIN_IN,
	// status
	output logic            TX_FREE_INDICATOR,
	output logic            TX_READY_IRQ,
	output logic            SERIAL_IRQ_FLAG
);

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	sptx_pkg::sptx_mode_t mode;
	logic                 sync_mode;
	logic                 master_mode;

	// unsupported or sync requests on a plain channel fall back to uart
	always_comb begin
		mode = sptx_pkg::SPTX_MODE_UART;
		if (SYNC_CAPABLE && TX_MODE == sptx_pkg::SPTX_MODE_MASTER) begin
			mode = sptx_pkg::SPTX_MODE_MASTER;
		end else if (SYNC_CAPABLE && TX_MODE == sptx_pkg::SPTX_MODE_SLAVE) begin
			mode = sptx_pkg::SPTX_MODE_SLAVE;
		end
	end
	assign sync_mode   = (mode != sptx_pkg::SPTX_MODE_UART);
	assign master_mode = (mode == sptx_pkg::SPTX_MODE_MASTER);

	// ------------------------------------------------------------
	// holding buffer (fifo) and start pulse
	// ------------------------------------------------------------
	logic       fifo_valid;
	logic       fifo_ready;
	logic [8:0] fifo_data;
	logic       write_seen;
	logic       start_pulse;
	logic       start_fall;
	logic       load_ok;

	sptx_fifo #(
		.WIDTH (sptx_pkg::SPTX_DATA_W + 1),
		.DEPTH (sptx_pkg::SPTX_FIFO_DEPTH)
	) u_hold (
		.clk       (REF_CLK),
		.rst_n     (RST_N),
		.in_valid  (TX_BUFFER_WRITE_STROBE),
		.in_ready  (fifo_ready),
		.in_data   ({TX_ADDRESS_MARK, TX_WRITE_DATA}),
		.out_valid (fifo_valid),
		.out_ready (start_fall),
		.out_data  (fifo_data)
	);

	// write accepted flag, then a one-clock start pulse after it
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			write_seen  <= 1'b0;
			start_pulse <= 1'b0;
		end else begin
			write_seen  <= TX_BUFFER_WRITE_STROBE && fifo_ready;
			start_pulse <= (write_seen || fifo_valid) && load_ok && !start_pulse;
		end
	end
	// the pulse falls on the clock after it rises; loading there keeps one word per pulse
	assign start_fall = start_pulse && fifo_valid;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			TX_WRITE_READY <= 1'b0;
		end else begin
			TX_WRITE_READY <= fifo_ready;
		end
	end

	// ------------------------------------------------------------
	// shift tick generation
	// ------------------------------------------------------------
	logic       clk_in_s1;
	logic       clk_in_s2;
	logic       clk_in_s3;
	logic [3:0] div_cnt;
	logic [3:0] div_top;
	logic       shift_tick;
	logic       busy;

	// two-stage synchroniser, third stage only feeds the edge detector
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			clk_in_s1 <= 1'b1;
			clk_in_s2 <= 1'b1;
			clk_in_s3 <= 1'b1;
		end else begin
			clk_in_s1 <= TX_CLOCK_PIN_IN;
			clk_in_s2 <= clk_in_s1;
			clk_in_s3 <= clk_in_s2;
		end
	end

	assign div_top = sync_mode ? sptx_pkg::SPTX_SYNC_DIV_M1 : sptx_pkg::SPTX_UART_DIV_M1;

	// divider held in reset while idle so the first tick is a full period away
	always_ff @(posedge REF_CLK) begin
		if (!RST_N || !busy) begin
			div_cnt <= sptx_pkg::SPTX_DIV_ZERO;
		end else if (BAUD_TICK) begin
			div_cnt <= (div_cnt >= div_top) ? sptx_pkg::SPTX_DIV_ZERO : div_cnt + 4'h0_001;
		end
	end

	// slave uses the falling edge of the external clock as its tick
	always_comb begin
		if (mode == sptx_pkg::SPTX_MODE_SLAVE) begin
			shift_tick = clk_in_s3 && !clk_in_s2;
		end else begin
			shift_tick = busy && BAUD_TICK && (div_cnt >= div_top);
		end
	end

	// ------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------
	sptx_pkg::sptx_state_t state;
	logic [7:0]            shifter;
	logic                  mpc_bit;
	logic [2:0]            bit_idx;
	logic [1:0]            lead_cnt;
	logic                  parity_acc;
	logic                  next_tx_data;
	logic                  frame_end;
	logic                  sclk_run;

	assign busy    = (state != sptx_pkg::SPTX_ST_IDLE);
	// a new word may load in idle or at the very tick that closes a frame
	assign load_ok = !busy || frame_end;

	always_comb begin
		frame_end = 1'b0;
		if (shift_tick) begin
			if (state == sptx_pkg::SPTX_ST_STOP) begin
				frame_end = 1'b1;
			end else if (sync_mode && state == sptx_pkg::SPTX_ST_PARITY) begin
				frame_end = 1'b1;
			end else if (sync_mode && state == sptx_pkg::SPTX_ST_MPC && !TX_PARITY_ENABLE) begin
				frame_end = 1'b1;
			end else if (sync_mode && state == sptx_pkg::SPTX_ST_DATA && bit_idx == sptx_pkg::SPTX_LAST_BIT
				&& !TX_MULTIPROC_ENABLE && !TX_PARITY_ENABLE) begin
				frame_end = 1'b1;
			end
		end
	end

	// state and data path; each bit step happens on a shift tick
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			state      <= sptx_pkg::SPTX_ST_IDLE;
			shifter    <= '0;
			mpc_bit    <= 1'b0;
			bit_idx    <= sptx_pkg::SPTX_BIT_ZERO;
			lead_cnt   <= sptx_pkg::SPTX_LEAD_ZERO;
			parity_acc <= 1'b0;
		end else if (start_fall) begin
			shifter    <= fifo_data[7:0];
			mpc_bit    <= fifo_data[8];
			bit_idx    <= sptx_pkg::SPTX_BIT_ZERO;
			lead_cnt   <= sptx_pkg::SPTX_LEAD_ZERO;
			parity_acc <= TX_PARITY_ODD;
			case (mode)
				sptx_pkg::SPTX_MODE_MASTER: state <= sptx_pkg::SPTX_ST_LEAD;
				sptx_pkg::SPTX_MODE_SLAVE:  state <= sptx_pkg::SPTX_ST_DATA;
				// uart waits in lead for its first tick; a chained word keeps the start bit already on the line
				default:                    state <= busy ? sptx_pkg::SPTX_ST_START : sptx_pkg::SPTX_ST_LEAD;
			endcase
		end else if (frame_end) begin
			// a pending uart word starts its start bit right on the closing tick
			state <= (!sync_mode && fifo_valid) ? sptx_pkg::SPTX_ST_START : sptx_pkg::SPTX_ST_IDLE;
		end else if (shift_tick) begin
			case (state)
				sptx_pkg::SPTX_ST_LEAD: begin
					lead_cnt <= lead_cnt + 2'h0_001;
					if (!sync_mode) begin
						state <= sptx_pkg::SPTX_ST_START;
					end else if (lead_cnt + 2'h0_001 == sptx_pkg::SPTX_LEAD_TICKS) begin
						state <= sptx_pkg::SPTX_ST_DATA;
					end
				end
				sptx_pkg::SPTX_ST_START: begin
					state <= sptx_pkg::SPTX_ST_DATA;
				end
				sptx_pkg::SPTX_ST_DATA: begin
					parity_acc <= parity_acc ^ shifter[0];
					shifter    <= {1'b0, shifter[7:1]};
					bit_idx    <= bit_idx + 3'h0_001;
					if (bit_idx == sptx_pkg::SPTX_LAST_BIT) begin
						if (TX_MULTIPROC_ENABLE) begin
							state <= sptx_pkg::SPTX_ST_MPC;
						end else if (TX_PARITY_ENABLE) begin
							state <= sptx_pkg::SPTX_ST_PARITY;
						end else begin
							state <= sptx_pkg::SPTX_ST_STOP;
						end
					end
				end
				sptx_pkg::SPTX_ST_MPC: begin
					parity_acc <= parity_acc ^ mpc_bit;
					state      <= TX_PARITY_ENABLE ? sptx_pkg::SPTX_ST_PARITY : sptx_pkg::SPTX_ST_STOP;
				end
				sptx_pkg::SPTX_ST_PARITY: begin
					state <= sptx_pkg::SPTX_ST_STOP;
				end
				default: begin
					state <= sptx_pkg::SPTX_ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	// line level for the current state; registered so it moves one clock after the tick
	always_comb begin
		case (state)
			sptx_pkg::SPTX_ST_START:  next_tx_data = 1'b0;
			sptx_pkg::SPTX_ST_DATA:   next_tx_data = shifter[0];
			sptx_pkg::SPTX_ST_MPC:    next_tx_data = mpc_bit;
			sptx_pkg::SPTX_ST_PARITY: next_tx_data = parity_acc;
			default:                  next_tx_data = sptx_pkg::SPTX_LINE_IDLE;
		endcase
		if (!TX_PIN_SERIAL_SELECT) begin
			next_tx_data = sptx_pkg::SPTX_LINE_IDLE;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			TX_DATA_PIN <= sptx_pkg::SPTX_LINE_IDLE;
		end else begin
			TX_DATA_PIN <= next_tx_data;
		end
	end

	// master clock out: low half after each tick, the peer samples on the rise
	assign sclk_run = master_mode && (state == sptx_pkg::SPTX_ST_DATA || state == sptx_pkg::SPTX_ST_MPC
		|| state == sptx_pkg::SPTX_ST_PARITY);

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			TX_CLOCK_PIN_OUT <= 1'b1;
			TX_CLOCK_PIN_OE  <= 1'b0;
		end else begin
			TX_CLOCK_PIN_OE <= master_mode;
			// data turns one clock before the falling clock edge lands
			if (!sclk_run) begin
				TX_CLOCK_PIN_OUT <= 1'b1;
			end else if (div_cnt == sptx_pkg::SPTX_HALF) begin
				TX_CLOCK_PIN_OUT <= 1'b1;
			end else if (BAUD_TICK && div_cnt == sptx_pkg::SPTX_DIV_ZERO) begin
				TX_CLOCK_PIN_OUT <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// status, interrupt request and flag
	// ------------------------------------------------------------
	logic ready_pending;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			TX_FREE_INDICATOR <= 1'b1;
		end else if (start_fall) begin
			TX_FREE_INDICATOR <= 1'b0;
		end else if (frame_end && !fifo_valid) begin
			TX_FREE_INDICATOR <= 1'b1;
		end
	end

	// the request waits for the next instruction boundary; set wins over clear
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			ready_pending   <= 1'b0;
			TX_READY_IRQ    <= 1'b0;
			SERIAL_IRQ_FLAG <= 1'b0;
		end else begin
			TX_READY_IRQ <= ready_pending && INSTRUCTION_BEGIN;
			if (start_fall) begin
				ready_pending <= 1'b1;
			end else if (INSTRUCTION_BEGIN) begin
				ready_pending <= 1'b0;
			end
			if (ready_pending && INSTRUCTION_BEGIN) begin
				SERIAL_IRQ_FLAG <= 1'b1;
			end else if (SERIAL_IRQ_FLAG_CLEAR) begin
				SERIAL_IRQ_FLAG <= 1'b0;
			end
		end
	end

endmodule : sptx_top

`default_nettype wire

// ===== verification/sptx_chk.sv
// sptx_chk: port-level assertions for the serial transmitter
// assumes: bound to sptx_top, one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module sptx_chk #(
	parameter logic SYNC_CAPABLE = 1'b1
) (
	// clock and reset
	input wire logic       REF_CLK,
	input wire logic       RST_N,
	// cpu side
	input wire logic       TX_BUFFER_WRITE_STROBE,
	input wire logic       TX_WRITE_READY,
	input wire logic       INSTRUCTION_BEGIN,
	input wire logic       SERIAL_IRQ_FLAG_CLEAR,
	// configuration and pins
	input wire logic [1:0] TX_MODE,
	input wire logic       BAUD_TICK,
	input wire logic       TX_DATA_PIN,
	input wire logic       TX_CLOCK_PIN_OE,
	// status
	input wire logic       TX_FREE_INDICATOR,
	input wire logic       TX_READY_IRQ,
	input wire logic       SERIAL_IRQ_FLAG
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// ------------------------------------------------------------
	// baud ticks since the last pin change inside a frame
	// ------------------------------------------------------------
	logic [7:0] tick_cnt;
	logic       armed;
	// the first edge after idle is not checked: there is no earlier pin change in the frame to count from
	always_ff @(posedge REF_CLK) begin
		if (!RST_N || TX_FREE_INDICATOR) begin
			tick_cnt <= 8'h00;
			armed    <= 1'b0;
		end else if ($changed(TX_DATA_PIN)) begin
			tick_cnt <= {7'h00, BAUD_TICK};
			armed    <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + {7'h00, BAUD_TICK};
		end
	end

	sequence s_write_idle;
		TX_BUFFER_WRITE_STROBE && TX_WRITE_READY && TX_FREE_INDICATOR;
	endsequence
	sequence s_load;
		##[3:4] !TX_FREE_INDICATOR;
	endsequence

	AST_START_DELAY: assert property (s_write_idle |-> s_load)
		else $error("free indicator not low after an idle write");
	AST_WRITE_STARTS: assert property ($fell(TX_FREE_INDICATOR) |->
		$past(TX_BUFFER_WRITE_STROBE, 3) || $past(TX_BUFFER_WRITE_STROBE, 4))
		else $error("frame started without a buffer write");
	AST_IDLE_HIGH: assert property (TX_FREE_INDICATOR && $past(TX_FREE_INDICATOR) |-> TX_DATA_PIN)
		else $error("data pin low while idle");
	AST_IRQ_PULSE: assert property (TX_READY_IRQ |=> !TX_READY_IRQ)
		else $error("ready irq longer than one cycle");
	AST_IRQ_AT_BEGIN: assert property (TX_READY_IRQ |-> $past(INSTRUCTION_BEGIN))
		else $error("ready irq not aligned to instruction begin");
	AST_IRQ_SETS_FLAG: assert property (TX_READY_IRQ |-> SERIAL_IRQ_FLAG)
		else $error("flag not set with ready irq");
	AST_FLAG_STICKY: assert property (SERIAL_IRQ_FLAG && !SERIAL_IRQ_FLAG_CLEAR |=> SERIAL_IRQ_FLAG)
		else $error("flag dropped without clear");
	AST_UART_ON_TICK: assert property ($changed(TX_DATA_PIN) && !TX_FREE_INDICATOR
		&& TX_MODE == sptx_pkg::SPTX_MODE_UART |-> $past(BAUD_TICK, 2))
		else $error("uart pin change not one clock after a tick");
	AST_UART_BIT_TIME: assert property (armed && $changed(TX_DATA_PIN) && TX_MODE == sptx_pkg::SPTX_MODE_UART
		|-> tick_cnt[3:0] == 4'h0 && tick_cnt != 8'h00)
		else $error("uart bit not a multiple of sixteen ticks");
	AST_MASTER_OE: assert property ($past(TX_MODE) == TX_MODE |->
		TX_CLOCK_PIN_OE == (SYNC_CAPABLE && TX_MODE == sptx_pkg::SPTX_MODE_MASTER))
		else $error("clock pin enable does not follow mode");
endmodule : sptx_chk

bind sptx_top sptx_chk #(.SYNC_CAPABLE(SYNC_CAPABLE)) i_chk (
	.REF_CLK, .RST_N, .TX_BUFFER_WRITE_STROBE, .TX_WRITE_READY, .INSTRUCTION_BEGIN,
	.SERIAL_IRQ_FLAG_CLEAR, .TX_MODE, .BAUD_TICK, .TX_DATA_PIN, .TX_CLOCK_PIN_OE,
	.TX_FREE_INDICATOR, .TX_READY_IRQ, .SERIAL_IRQ_FLAG
);
`default_nettype wire

// ===== verification/sptx_peer.sv
// sptx_peer: synchronous serial peer, makes the slave clock, captures bits
// assumes: testbench resolves the clock pin and calls clear and run
`timescale 1ns/100ps
`default_nettype none

module sptx_peer (
	// pin side
	input  wire logic sclk_pin,
	input  wire logic data_pin,
	input  wire logic clk_oe,
	// own clock for slave mode, stands high outside frames
	output logic      peer_clk
);
	logic [15:0] rx_bits;
	int          rx_count;
	initial peer_clk = 1'b1;
	// master mode: take data on the rising shift clock
	always @(posedge sclk_pin) begin
		if (clk_oe === 1'b1) begin
			rx_bits[rx_count] = data_pin;
			rx_count = rx_count + 1;
		end
	end
	task automatic clear();
		rx_bits = 16'h0000;
		rx_count = 0;
	endtask : clear
	// slave mode: slow unrelated clock the device edge-detects
	// sampled late in the high phase, well after the last change
	task automatic run(input int n);
		repeat (n) begin
			#110;
			rx_bits[rx_count] = data_pin;
			rx_count = rx_count + 1;
			peer_clk = 1'b0;
			#110 peer_clk = 1'b1;
		end
	endtask : run
endmodule : sptx_peer
`default_nettype wire

// ===== verification/tb_top.sv
// tb_top: self-checking bench for the serial transmitter
// assumes: baud tick every second clock, instruction begin every seventh
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	localparam int BIT = 32;  // two clocks per tick, sixteen ticks per uart bit
	logic       ref_clk, rst_n, wr, addr_mark, ins_begin, flag_clr, par_en, par_odd, mpc_en, tick, pin_sel;
	logic [7:0] wdata;
	logic [1:0] mode;
	logic       txd, clk_out, clk_oe, free, irq, flag, wr_ready;
	wire logic  clk_pin, peer_clk;
	int         num_errors, check_count, cyc;
	// the shared clock pin: device drives it only in master mode
	assign clk_pin = clk_oe ? clk_out : peer_clk;

	sptx_top i_dut (
		.REF_CLK(ref_clk), .RST_N(rst_n), .TX_BUFFER_WRITE_STROBE(wr), .TX_WRITE_DATA(wdata),
		.TX_ADDRESS_MARK(addr_mark), .TX_WRITE_READY(wr_ready), .INSTRUCTION_BEGIN(ins_begin),
		.SERIAL_IRQ_FLAG_CLEAR(flag_clr), .TX_MODE(mode), .TX_PARITY_ENABLE(par_en),
		.TX_PARITY_ODD(par_odd), .TX_MULTIPROC_ENABLE(mpc_en), .TX_PIN_SERIAL_SELECT(pin_sel),
		.BAUD_TICK(tick), .TX_DATA_PIN(txd), .TX_CLOCK_PIN_OUT(clk_out), .TX_CLOCK_PIN_OE(clk_oe),
		.TX_CLOCK_PIN_IN(clk_pin), .TX_FREE_INDICATOR(free), .TX_READY_IRQ(irq), .SERIAL_IRQ_FLAG(flag)
	);
	sptx_peer i_peer (.sclk_pin(clk_pin), .data_pin(txd), .clk_oe(clk_oe), .peer_clk(peer_clk));

	// ------------------------------------------------------------
	// clock, free-running stimulus, helpers
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// periodic inputs change just after the edge, like every input but the peer's slave clock
	always @(posedge ref_clk) begin
		#2;
		cyc = cyc + 1;
		tick = cyc[0];
		ins_begin = (cyc % 7 == 0);
	end
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : step
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	// waits are bounded; ready lags a cycle, so writes are two cycles apart
	task automatic write(input logic [7:0] d, input logic a);
		int n;
		n = 0;
		while (wr_ready !== 1'b1 && n < 2000) begin
			step(1);
			n++;
		end
		check("write ready", {15'h0000, wr_ready}, 16'h0001);
		wr = 1'b1;
		wdata = d;
		addr_mark = a;
		step(1);
		wr = 1'b0;
		step(1);
	endtask : write
	task automatic wait_free(input logic v, input int max);
		int n;
		n = 0;
		while (free !== v && n < max) begin
			step(1);
			n++;
		end
		check("free indicator", {15'h0000, free}, {15'h0000, v});
	endtask : wait_free
	// receives one uart frame, sampling mid-bit from the start edge
	task automatic uart_frame(input logic [7:0] d, input logic a, input int wait_max);
		logic [11:0] bits;
		int          len;
		int          n;
		bits = {3'b111, d, 1'b0};
		len = 9;
		if (mpc_en) begin
			bits[len] = a;
			len++;
		end
		if (par_en) begin
			bits[len] = par_odd ^ (^d) ^ (mpc_en & a);
			len++;
		end
		bits[len] = 1'b1;
		len++;
		n = 0;
		while (txd !== 1'b0 && n < wait_max) begin
			step(1);
			n++;
		end
		step(BIT / 2);
		for (int i = 0; i < len; i++) begin
			check("uart bit", {15'h0000, txd}, {15'h0000, bits[i]});
			if (i < len - 1)
				step(BIT);
		end
	endtask : uart_frame

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_uart_cfgs();
		logic [2:0] cfg [4] = '{3'b000, 3'b100, 3'b110, 3'b001};
		logic [7:0] dat [4] = '{8'h96, 8'h01, 8'h80, 8'h5C};
		mode = sptx_pkg::SPTX_MODE_UART;
		for (int i = 0; i < 4; i++) begin
			{par_en, par_odd, mpc_en} = cfg[i];
			write(dat[i], i[1]);
			uart_frame(dat[i], i[1], 60);
			wait_free(1'b1, 40);
		end
		$display("test uart_cfgs done");
	endtask : t_uart_cfgs
	// deselected pin stays high even while a frame runs underneath
	task automatic t_pin_sel();
		pin_sel = 1'b0;
		write(8'h00, 1'b0);
		step(40);
		check("pin while deselected", {15'h0000, txd}, 16'h0001);
		wait_free(1'b1, 400);
		pin_sel = 1'b1;
		$display("test pin_sel done");
	endtask : t_pin_sel
	task automatic t_irq();
		int n;
		flag_clr = 1'b1;
		step(2);
		flag_clr = 1'b0;
		check("flag cleared", {15'h0000, flag}, 16'h0000);
		write(8'h3C, 1'b0);
		n = 0;
		while (irq !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		check("ready irq", {15'h0000, irq}, 16'h0001);
		check("flag set", {15'h0000, flag}, 16'h0001);
		uart_frame(8'h3C, 1'b0, 60);
		wait_free(1'b1, 40);
		$display("test irq done");
	endtask : t_irq
	// five writes fill shifter and fifo; frames must then run back to back
	task automatic t_fill();
		{par_en, par_odd, mpc_en} = 3'b000;
		fork
			begin
				for (int k = 0; k < 5; k++)
					write(8'h10 + 8'(k), 1'b0);
				step(2);
				check("write ready when full", {15'h0000, wr_ready}, 16'h0000);
			end
			for (int k = 0; k < 5; k++)
				uart_frame(8'h10 + 8'(k), 1'b0, k == 0 ? 60 : BIT / 2 + 3);
		join
		wait_free(1'b1, 40);
		$display("test fill done");
	endtask : t_fill
	task automatic t_master();
		mode = sptx_pkg::SPTX_MODE_MASTER;
		i_peer.clear();
		write(8'h3A, 1'b0);
		check("clock enable", {15'h0000, clk_oe}, 16'h0001);
		wait_free(1'b0, 10);
		wait_free(1'b1, 400);
		check("master count", 16'(i_peer.rx_count), 16'h0008);
		check("master data", i_peer.rx_bits, 16'h003A);
		$display("test master done");
	endtask : t_master
	task automatic t_slave();
		mode = sptx_pkg::SPTX_MODE_SLAVE;
		i_peer.clear();
		write(8'hC5, 1'b0);
		wait_free(1'b0, 10);
		step(1);
		check("slave bit0", {15'h0000, txd}, 16'h0001);
		check("clock enable", {15'h0000, clk_oe}, 16'h0000);
		i_peer.run(8);
		wait_free(1'b1, 100);
		check("slave data", i_peer.rx_bits, 16'h00C5);
		$display("test slave done");
	endtask : t_slave

	// main sequence: reset five cycles, then scenarios in turn
	initial begin
		{rst_n, wr, addr_mark, ins_begin, flag_clr, par_en, par_odd, mpc_en, tick} = 9'h000;
		{wdata, mode, cyc, num_errors, check_count} = '0;
		pin_sel = 1'b1;
		step(5);
		rst_n = 1'b1;
		step(2);
		check("idle pin", {15'h0000, txd}, 16'h0001);
		t_pin_sel();
		t_uart_cfgs();
		t_irq();
		t_fill();
		t_master();
		t_slave();
		stop_test();
	end
	// watchdog: the scenarios need well under ten thousand cycles
	initial begin
		#500000;
		num_errors++;
		$display("watchdog expired");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
